// File: hw/sadc_pkg.sv
// Constants, register map and result formatting for the converter control.
// Functional notes
// - Left format: bits 9..2 high, 1..0 low top
// - Right format: bits 9..8 high low, 7..0 low
// - Justify select bit picks the format
// - 8-bit result in high byte, low reads zero
// - 10-bit: unused six bits read zero
// - Result registers are read-only
// - Pin enable write aborts, starts nothing
// - Disabled pin converts low reference, gives zero
// - Pin enable: one bit per pin
// - Status/control write aborts then starts conversion
// - Configuration write aborts, starts nothing
// - Mode control, sample-hold, SAR handshake sequence
// - Reference conversions bypass the sample-hold machine
// - Results go to a dual-port store
// - Sample-hold and SAR never active together
// - Sample-hold clocks gated off when idle
// - Sampling window is 14 conversion clocks
// - Conversion clock from bus clock via prescaler
// - Done flag set on completion, cleared by access
// - Interrupt follows done flag while enabled
// - Continuous mode repeats, else one per write
// - Channel codes: pins 0-7, 1E high, else low
package sadc_pkg;

  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CONV_MAX_HZ = 2_000_000;
  localparam int unsigned TICK_MIN_DIV =
    (CLK_HZ + CONV_MAX_HZ - 1) / CONV_MAX_HZ;
  localparam logic [3:0] PRS_RST = 4'((TICK_MIN_DIV + 1) / 2 - 1);
  localparam logic [3:0] SAMPLE_TICKS = 4'd14;

  localparam logic [7:0] OFS_SC = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_RH = 8'h08;
  localparam logic [7:0] OFS_RL = 8'h0C;
  localparam logic [7:0] OFS_PE = 8'h10;

  localparam int unsigned SC_DONE_BIT = 7;
  localparam int unsigned SC_IRQEN_BIT = 6;
  localparam int unsigned SC_CONT_BIT = 5;
  localparam int unsigned CFG_JUST_BIT = 6;
  localparam int unsigned CFG_TEN_BIT = 5;

  localparam logic [4:0] CH_PIN_LAST = 5'h07;
  localparam logic [4:0] CH_HIGH_REF = 5'h1E;

  localparam logic [6:0] SC_RST = 7'h1F;
  localparam logic [7:0] CFG_RST = {4'h2, PRS_RST};
  localparam logic [7:0] PE_RST = 8'h00;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SADC_IDLE,
    SADC_SAMPLE,
    SADC_CONVERT,
    SADC_STORE
  } sadc_state_e;

  // Returns {high byte, low byte} of a finished conversion.
  function automatic logic [15:0] sadc_format(
    input logic [9:0] code,
    input logic right,
    input logic ten
  );
    logic [15:0] v;
    v = 16'h0000;
    if (!ten)
    begin
      v = {code[9:2], 8'h00};
    end
    else if (right)
    begin
      v = {6'h00, code[9:8], code[7:0]};
    end
    else
    begin
      v = {code[9:2], code[1:0], 6'h00};
    end
    return v;
  endfunction

endpackage

// File: hw/sadc_sar.sv
// Successive approximation machine with reference bypass.
`timescale 1ns/1ps
module sadc_sar #(
  parameter int unsigned WIDTH = 10
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Sequencing.
  input wire logic tick,
  input wire logic start,
  input wire logic abort,
  input wire logic ten_bit,
  input wire logic force_hi,
  input wire logic force_lo,
  input wire logic cmp_above,
  output logic busy,
  output logic done,
  output logic [WIDTH-1:0] code
);

  logic [3:0] idx_r;
  logic [WIDTH-1:0] code_r;
  logic busy_r;
  logic done_r;
  logic keep;
  logic [3:0] last_idx;

  if (WIDTH != 10)
  begin : g_chk
    $error("sadc_sar supports a 10-bit result only");
  end

  // References set the decision directly instead of the held sample.
  assign keep = force_hi ? 1'b1 : (force_lo ? 1'b0 : cmp_above);
  assign last_idx = ten_bit ? 4'd0 : 4'd2;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || abort)
    begin
      busy_r <= 1'b0;
      idx_r <= 4'd0;
    end
    else if (start)
    begin
      busy_r <= 1'b1;
      idx_r <= 4'(WIDTH - 1);
    end
    else if (busy_r && tick)
    begin
      if (idx_r == last_idx)
      begin
        busy_r <= 1'b0;
      end
      else
      begin
        idx_r <= idx_r - 4'd1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      code_r <= '0;
    end
    else if (start)
    begin
      code_r <= {1'b1, {(WIDTH - 1){1'b0}}};
    end
    else if (busy_r && tick)
    begin
      code_r[idx_r] <= keep;
      if (idx_r != last_idx)
      begin
        code_r[idx_r - 4'd1] <= 1'b1;
      end
    end
  end

  // End of conversion back to the mode controller.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || abort)
    begin
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= busy_r && tick && (idx_r == last_idx);
    end
  end

  assign busy = busy_r;
  assign done = done_r;
  assign code = code_r;

endmodule

// File: hw/sadc_top.sv
// Converter control: register slave, mode control, sample window.
`timescale 1ns/1ps
module sadc_top #(
  parameter int unsigned ADDR_W = 8
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus write channels.
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Register bus read channels.
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analog front end.
  input wire logic cmp_above_pin,
  output logic [2:0] mux_sel,
  output logic sh_clk_en,
  output logic sar_active,
  output logic ref_high_sel,
  output logic ref_low_sel,
  output logic [9:0] dac_code,
  // Done request.
  output logic irq
);
  import sadc_pkg::*;

  if (ADDR_W < 5)
  begin : g_chk
    $error("sadc_top needs at least 5 address bits");
  end

  logic [6:0] sc_r;
  logic done_flag_r;
  logic [7:0] cfg_r;
  logic [7:0] pin_en_r;
  logic [7:0] store_r [0:1];

  logic aw_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic w_held_r;
  logic [7:0] wdata_r;
  logic wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  logic wr_fire;
  logic wr_sc;
  logic wr_cfg;
  logic wr_pe;
  logic wr_known;
  logic rd_fire;
  logic rd_res;
  logic abort;

  sadc_state_e state_r;
  logic go_r;
  logic [4:0] div_r;
  logic tick;
  logic [3:0] win_r;
  logic sel_hi_r;
  logic sel_lo_r;
  logic [2:0] mux_r;
  logic ten_r;
  logic right_r;
  logic sar_start;
  logic sar_busy;
  logic sar_done;
  logic [9:0] sar_code;
  logic cmp_s1_r;
  logic cmp_s2_r;
  logic cmp_s3_r;
  logic cmp_q_r;
  logic pin_ok;
  logic [15:0] fmt;

  function automatic logic is_addr(
    input logic [ADDR_W-1:0] a,
    input logic [7:0] ofs
  );
    return a == ADDR_W'(ofs);
  endfunction

  // Write address and data are taken in either order, then answered.
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
  assign wr_sc = wr_fire && wstrb_r && is_addr(awaddr_r, OFS_SC);
  assign wr_cfg = wr_fire && wstrb_r && is_addr(awaddr_r, OFS_CFG);
  assign wr_pe = wr_fire && wstrb_r && is_addr(awaddr_r, OFS_PE);
  assign wr_known = is_addr(awaddr_r, OFS_SC) ||
    is_addr(awaddr_r, OFS_CFG) || is_addr(awaddr_r, OFS_PE) ||
    is_addr(awaddr_r, OFS_RH) || is_addr(awaddr_r, OFS_RL);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      awaddr_r <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end
    else if (wr_fire)
    begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_r <= 1'b0;
      wdata_r <= 8'h00;
      wstrb_r <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata[7:0];
      wstrb_r <= s_axi_wstrb[0];
    end
    else if (wr_fire)
    begin
      w_held_r <= 1'b0;
    end
  end

  // Result addresses accept the write but keep their contents.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_known ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      bvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sc_r <= SC_RST;
    end
    else if (wr_sc)
    begin
      sc_r <= wdata_r[6:0];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_r <= CFG_RST;
    end
    else if (wr_cfg)
    begin
      cfg_r <= wdata_r;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_en_r <= PE_RST;
    end
    else if (wr_pe)
    begin
      pin_en_r <= wdata_r;
    end
  end

  // Read channel; a result read also clears the done flag.
  assign s_axi_arready = !rvalid_r;
  assign rd_fire = s_axi_arvalid && !rvalid_r;
  assign rd_res = rd_fire && (is_addr(s_axi_araddr, OFS_RH) ||
    is_addr(s_axi_araddr, OFS_RL));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid_r <= 1'b1;
      rresp_r <= RESP_OKAY;
      if (is_addr(s_axi_araddr, OFS_SC))
      begin
        rdata_r <= {24'h000000, done_flag_r, sc_r};
      end
      else if (is_addr(s_axi_araddr, OFS_CFG))
      begin
        rdata_r <= {24'h000000, cfg_r};
      end
      else if (is_addr(s_axi_araddr, OFS_RH))
      begin
        rdata_r <= {24'h000000, store_r[0]};
      end
      else if (is_addr(s_axi_araddr, OFS_RL))
      begin
        rdata_r <= {24'h000000, store_r[1]};
      end
      else if (is_addr(s_axi_araddr, OFS_PE))
      begin
        rdata_r <= {24'h000000, pin_en_r};
      end
      else
      begin
        rdata_r <= 32'h0000_0000;
        rresp_r <= RESP_SLVERR;
      end
    end
    else if (s_axi_rready)
    begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // A write to any control register ends the conversion under way.
  assign abort = wr_sc || wr_cfg || wr_pe;

  // Conversion clock: one tick every 2 * (prescale + 1) bus clocks.
  // It restarts with each conversion, so the window is 14 whole ticks.
  // Settings within the 2 MHz limit also give the comparator time to settle.
  assign tick = div_r == {cfg_r[3:0], 1'b1};

  always_ff @(posedge aclk)
  begin
    if (!aresetn || tick || (state_r == SADC_IDLE && go_r))
    begin
      div_r <= 5'h00;
    end
    else
    begin
      div_r <= div_r + 5'h01;
    end
  end

  // Comparator pin: three stages, a change counts once stages agree.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cmp_s1_r <= 1'b0;
      cmp_s2_r <= 1'b0;
      cmp_s3_r <= 1'b0;
      cmp_q_r <= 1'b0;
    end
    else
    begin
      cmp_s1_r <= cmp_above_pin;
      cmp_s2_r <= cmp_s1_r;
      cmp_s3_r <= cmp_s2_r;
      if (cmp_s2_r == cmp_s3_r)
      begin
        cmp_q_r <= cmp_s3_r;
      end
    end
  end

  // A pin is converted only if selected by code 00-07 and enabled.
  assign pin_ok = (sc_r[4:0] <= CH_PIN_LAST) &&
    pin_en_r[sc_r[2:0]];

  // Start request pending: set by a status/control write or a continuous restart.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || wr_cfg || wr_pe)
    begin
      go_r <= 1'b0;
    end
    else if (wr_sc)
    begin
      go_r <= 1'b1;
    end
    else if (state_r == SADC_STORE)
    begin
      go_r <= sc_r[SC_CONT_BIT];
    end
    else if (state_r == SADC_IDLE)
    begin
      go_r <= 1'b0;
    end
  end

  // Channel and format are frozen when a conversion starts.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sel_hi_r <= 1'b0;
      sel_lo_r <= 1'b1;
      mux_r <= 3'h0;
      ten_r <= 1'b0;
      right_r <= 1'b0;
    end
    else if (state_r == SADC_IDLE && go_r && !abort)
    begin
      sel_hi_r <= sc_r[4:0] == CH_HIGH_REF;
      sel_lo_r <= !pin_ok && (sc_r[4:0] != CH_HIGH_REF);
      mux_r <= sc_r[2:0];
      ten_r <= cfg_r[CFG_TEN_BIT];
      right_r <= cfg_r[CFG_JUST_BIT];
    end
  end

  // Mode control: sample for 14 ticks, then hand over to the SAR.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || abort)
    begin
      state_r <= SADC_IDLE;
      win_r <= 4'h0;
    end
    else
    begin
      case (state_r)
        SADC_IDLE:
        begin
          win_r <= 4'h0;
          if (go_r)
          begin
            if (pin_ok)
            begin
              state_r <= SADC_SAMPLE;
            end
            else
            begin
              state_r <= SADC_CONVERT;
            end
          end
        end
        SADC_SAMPLE:
        begin
          if (tick)
          begin
            win_r <= win_r + 4'h1;
            if (win_r == SAMPLE_TICKS - 4'h1)
            begin
              state_r <= SADC_CONVERT;
            end
          end
        end
        SADC_CONVERT:
        begin
          if (sar_done)
          begin
            state_r <= SADC_STORE;
          end
        end
        SADC_STORE:
        begin
          state_r <= SADC_IDLE;
        end
        default:
        begin
          state_r <= SADC_IDLE;
        end
      endcase
    end
  end

  // The SAR starts as the sample window closes or at once for references.
  assign sar_start = !abort && (
    (state_r == SADC_SAMPLE && tick && win_r == SAMPLE_TICKS - 4'h1) ||
    (state_r == SADC_IDLE && go_r && !pin_ok));

  sadc_sar #(
    .WIDTH(10)
  ) u_sar (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .start(sar_start),
    .abort(abort),
    .ten_bit(ten_r),
    .force_hi(sel_hi_r),
    .force_lo(sel_lo_r),
    .cmp_above(cmp_q_r),
    .busy(sar_busy),
    .done(sar_done),
    .code(sar_code)
  );

  // Dual-port store: written only on completion, read by the bus.
  assign fmt = sadc_format(sar_code, right_r, ten_r);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      store_r[0] <= 8'h00;
      store_r[1] <= 8'h00;
    end
    else if (state_r == SADC_STORE)
    begin
      store_r[0] <= fmt[15:8];
      store_r[1] <= fmt[7:0];
    end
  end

  // Completion beats a clearing access in the same cycle.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      done_flag_r <= 1'b0;
    end
    else if (state_r == SADC_STORE)
    begin
      done_flag_r <= 1'b1;
    end
    else if (wr_sc || rd_res)
    begin
      done_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= sc_r[SC_IRQEN_BIT] && done_flag_r;
    end
  end

  // Sampling clocks run only inside the window; never with the SAR.
  assign sh_clk_en = state_r == SADC_SAMPLE;
  assign sar_active = sar_busy;
  assign mux_sel = mux_r;
  assign ref_high_sel = sel_hi_r;
  assign ref_low_sel = sel_lo_r;
  assign dac_code = sar_code;

endmodule

// File: dv/sadc_afe_model.sv
// Analog front end model: hold capacitor and comparator.
`timescale 1ns/1ps
module sadc_afe_model (
  // Clock.
  input wire logic aclk,
  // Converter side.
  input wire logic [2:0] mux_sel,
  input wire logic sh_clk_en,
  input wire logic ref_high_sel,
  input wire logic ref_low_sel,
  input wire logic [9:0] dac_code,
  output logic cmp_above_pin
);
  logic [9:0] lvl [8];
  logic [9:0] held_r = 10'h155;
  initial
    foreach (lvl[i])
      lvl[i] = 10'h155;
  // The hold node only follows the pin while the window is open.
  always @(posedge aclk)
    if (sh_clk_en)
      held_r <= lvl[mux_sel];
  assign cmp_above_pin = ref_high_sel ? 1'b1 :
    ref_low_sel ? (dac_code == 10'h000) : (held_r >= dac_code);
endmodule

// File: dv/sadc_top_monitor.sv
// Port checker for the converter control.
`timescale 1ns/1ps
module sadc_top_monitor #(
  parameter int unsigned ADDR_W = 8
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  // Converter side.
  input wire logic sh_clk_en,
  input wire logic sar_active,
  input wire logic ref_high_sel,
  input wire logic ref_low_sel
);
  import sadc_pkg::*;
  logic [8:0] samp_n_r;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !sh_clk_en)
      samp_n_r <= 9'h000;
    else
      samp_n_r <= samp_n_r + 9'h001;
  end
  a_no_overlap:
    assert property (!(sh_clk_en && sar_active))
    else $error("sample and convert overlap");
  a_ref_bypass:
    assert property (sh_clk_en |-> !(ref_high_sel || ref_low_sel))
    else $error("reference conversion sampled");
  a_window_cap:
    assert property (sh_clk_en |-> samp_n_r < 9'h1C0)
    else $error("sample window too long");
  a_write_resp:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_b_refuse:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_read_resp:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_read_upper:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_unmapped_err:
    assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > OFS_PE
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h00000000)
    else $error("unmapped read not refused");
  c_sample: cover property ($rose(sh_clk_en));
  c_convert: cover property ($rose(sar_active));
  c_ref: cover property ($rose(sar_active) && ref_high_sel);
endmodule

bind sadc_top sadc_top_monitor #(.ADDR_W(ADDR_W)) u_mon (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .sh_clk_en, .sar_active, .ref_high_sel, .ref_low_sel
);

// File: dv/sadc_top_tb_top.sv
// Self-checking bench for the converter control.
`timescale 1ns/1ps
module sadc_top_tb_top;
  import sadc_pkg::*;
  logic aclk, aresetn, cmp_above_pin, sh_clk_en, sar_active, irq;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, ref_high_sel, ref_low_sel;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] mux_sel;
  logic [9:0] dac_code;
  int num_errors, num_checks, cyc, samp_n, sar_n;

  sadc_top dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cmp_above_pin, .mux_sel, .sh_clk_en,
    .sar_active, .ref_high_sel, .ref_low_sel, .dac_code, .irq
  );
  sadc_afe_model afe (
    .aclk, .mux_sel, .sh_clk_en, .ref_high_sel, .ref_low_sel, .dac_code,
    .cmp_above_pin
  );

  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // Counters sample mid-cycle so they never race the clock edge.
  always @(negedge aclk)
  begin
    cyc++;
    samp_n += int'(sh_clk_en === 1'b1);
    sar_n += int'(sar_active === 1'b1);
    if (cyc == 20000)
    begin
      num_errors++;
      $display("[ERR] %0t timeout", $time);
      tally_and_finish();
    end
  end

  task tally_and_finish;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, d, input logic [1:0] er);
    logic aw_t, w_t;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(negedge aclk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (aw_t)
        s_axi_awvalid <= 1'b0;
      if (w_t)
        s_axi_wvalid <= 1'b0;
    end
    while ((s_axi_awvalid && !aw_t) || (s_axi_wvalid && !w_t));
    do
      @(negedge aclk);
    while (s_axi_bvalid !== 1'b1);
    chk(32'(s_axi_bresp), 32'(er));
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    logic t;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(negedge aclk);
      t = s_axi_arready;
      @(posedge aclk);
    end
    while (t !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do
      @(negedge aclk);
    while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
    chk(32'(r), 32'(RESP_OKAY));
  endtask

  task automatic wait_done;
    logic [31:0] d;
    logic [1:0] r;
    do
      rd(OFS_SC, d, r);
    while (d[SC_DONE_BIT] !== 1'b1);
  endtask

  task automatic conv(input logic [7:0] ch, cfg);
    wr(OFS_CFG, cfg, RESP_OKAY);
    wr(OFS_SC, ch, RESP_OKAY);
    wait_done();
  endtask

  task t_reset;
    rdc(OFS_SC, 32'(SC_RST));
    rdc(OFS_CFG, 32'(CFG_RST));
    rdc(OFS_RH, 32'h00);
    rdc(OFS_RL, 32'h00);
    rdc(OFS_PE, 32'h00);
    wr(OFS_PE, 8'hFF, RESP_OKAY);
    rdc(OFS_PE, 32'hFF);
  endtask

  task t_format;
    afe.lvl[3] = 10'h2D6;
    conv(8'h03, 8'h22);
    rdc(OFS_RH, 32'hB5);
    rdc(OFS_RL, 32'h80);
    rdc(OFS_SC, 32'h03);
    conv(8'h03, 8'h62);
    rdc(OFS_RH, 32'h02);
    rdc(OFS_RL, 32'hD6);
    conv(8'h03, 8'h42);
    rdc(OFS_RH, 32'hB5);
    rdc(OFS_RL, 32'h00);
  endtask

  task automatic t_refs;
    logic [7:0] ch [4] = '{8'h1E, 8'h1F, 8'h08, 8'h03};
    for (int i = 0; i < 4; i++)
    begin
      wr(OFS_PE, (i == 3) ? 8'hF7 : 8'hFF, RESP_OKAY);
      samp_n = 0;
      conv(ch[i], 8'h62);
      chk(samp_n, 0);
      rdc(OFS_RH, (i == 0) ? 32'h03 : 32'h00);
      rdc(OFS_RL, (i == 0) ? 32'hFF : 32'h00);
    end
    wr(OFS_PE, 8'hFF, RESP_OKAY);
  endtask

  task t_window;
    for (int p = 2; p < 4; p++)
    begin
      samp_n = 0;
      sar_n = 0;
      conv(8'h03, 8'h60 | 8'(p));
      chk(samp_n, 28 * (p + 1));
      chk(sar_n, 20 * (p + 1));
    end
  endtask

  task automatic t_abort;
    logic [7:0] ab [2] = '{OFS_PE, OFS_CFG};
    int c0;
    afe.lvl[3] = 10'h2A5;
    for (int i = 0; i < 2; i++)
    begin
      wr(OFS_SC, 8'h03, RESP_OKAY);
      repeat (10) @(posedge aclk);
      wr(ab[i], (i == 0) ? 8'hFF : 8'h62, RESP_OKAY);
      samp_n = 0;
      sar_n = 0;
      repeat (200) @(posedge aclk);
      chk(samp_n + sar_n, 0);
      rdc(OFS_SC, 32'h03);
      rdc(OFS_RL, 32'hD6);
    end
    wr(OFS_SC, 8'h03, RESP_OKAY);
    repeat (20) @(posedge aclk);
    wr(OFS_SC, 8'h03, RESP_OKAY);
    c0 = cyc;
    wait_done();
    chk(cyc - c0 >= 40, 1);
    rdc(OFS_RL, 32'hA5);
  endtask

  task automatic t_cont;
    logic [31:0] d;
    logic [1:0] r;
    int c;
    wr(OFS_SC, 8'h63, RESP_OKAY);
    for (int k = 0; k < 2; k++)
    begin
      c = 0;
      while (irq !== 1'b1 && c < 300)
      begin
        @(negedge aclk);
        c++;
      end
      chk(irq, 1);
      rd(OFS_RL, d, r);
      repeat (2) @(negedge aclk);
      chk(irq, 0);
    end
    wr(OFS_SC, 8'h03, RESP_OKAY);
    wait_done();
    sar_n = 0;
    repeat (200) @(posedge aclk);
    chk(sar_n, 0);
    chk(irq, 0);
  endtask

  task automatic t_bus;
    logic [31:0] d;
    logic [1:0] r;
    wr(OFS_RH, 8'h55, RESP_OKAY);
    wr(OFS_RL, 8'h5A, RESP_OKAY);
    rdc(OFS_RH, 32'h02);
    rdc(OFS_RL, 32'hA5);
    wr(8'h14, 8'h00, RESP_SLVERR);
    rd(8'h14, d, r);
    chk(32'(r), 32'(RESP_SLVERR));
    chk(d, 32'h00000000);
  endtask

  initial
  begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_format();
    t_refs();
    t_window();
    t_abort();
    t_cont();
    t_bus();
    tally_and_finish();
  end
endmodule
